// ---- src/nvs_slave.v ----
// How it works
// - array of 2048 bytes, each written on its own
// - each byte write completes at once, never busy
// - only a serial clock and a shared data line are used
// - data line is open drain: pull low or release
// - sample on clock rise, change own data on clock fall
// - write protect high: memory never changes
// - write protect low: whole array writable
// - reads work whatever write protect shows
// - open write protect reads as low, writes enabled
// - slave only, answers master transfers, never starts one
// - data line released whenever no bit is being driven
// - start condition begins every transfer, seen at any time
// - stop during a read ends it and goes to standby
// - stop during a write ends write data, goes standby
// - after a write stop, ready at once for new transfer
// - receiver pulls ninth clock low; transmitter releases it
// - first byte: type code, upper address, read bit; mismatch idles
// - 11-bit address from upper three bits and lower byte
// - address past last location wraps to zero
`timescale 1ns/1ps
`default_nettype none
`include "nvs_map.vh"
module nvs_slave #(
    parameter [3:0] TYPE_CODE = 4'h5, // arbitrary value
    parameter AW = `NVS_ADDR_W,
    parameter DW = `NVS_DATA_W,
    parameter DEPTH = `NVS_DEPTH,
    parameter FIFO_DEPTH = `NVS_FIFO_DEPTH
) (
    input wire sys_clk,
    input wire reset_n,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    input wire wp_in,
    output reg busy_active
);
    ////////////////////////////////////////////////////////////////////////
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_DEVADR = 6'h02;
    localparam [5:0] ST_LOWADR = 6'h04;
    localparam [5:0] ST_WRDATA = 6'h08;
    localparam [5:0] ST_RDDATA = 6'h10;
    localparam [5:0] ST_RDACK = 6'h20;
    localparam FW = AW + DW;

    ////////////////////////////////////////////////////////////////////////
    // two-stage synchronisers for pins
    reg scl_s1_r;
    reg scl_s2_r;
    reg scl_d_r;
    reg sda_s1_r;
    reg sda_s2_r;
    reg sda_d_r;
    reg wp_s1_r;
    reg wp_s2_r;

    // serial clock: idle level is high, so no false edge after reset
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_d_r <= 1'b1;
        end else begin
            scl_s1_r <= scl_in;
            scl_s2_r <= scl_s1_r;
            scl_d_r <= scl_s2_r;
        end
    end

    // data line read back, pulled high when nobody drives it
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            sda_s1_r <= sda_in;
            sda_s2_r <= sda_s1_r;
            sda_d_r <= sda_s2_r;
        end
    end

    // write protect: reset level low means writes enabled
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wp_s1_r <= 1'b0;
            wp_s2_r <= 1'b0;
        end else begin
            wp_s1_r <= wp_in;
            wp_s2_r <= wp_s1_r;
        end
    end

    wire scl_rise = scl_s2_r && !scl_d_r;
    wire scl_fall = !scl_s2_r && scl_d_r;
    // data edges while clock stays high are start and stop
    wire start_det = scl_s2_r && scl_d_r && sda_d_r && !sda_s2_r;
    wire stop_det = scl_s2_r && scl_d_r && !sda_d_r && sda_s2_r;

    ////////////////////////////////////////////////////////////////////////
    reg [5:0] state_r;
    reg [5:0] state_nxt;
    reg [3:0] bit_cnt_r;
    reg [DW-1:0] shift_r;
    reg [AW-1:0] addr_r;
    reg [DW-1:0] tx_r;
    reg ack_slot_r;
    reg ack_pend_r;
    wire [DW-1:0] rx_byte = {shift_r[DW-2:0], sda_s2_r};
    wire byte_done = scl_rise && (bit_cnt_r == `NVS_LAST_DATA_BIT);
    wire ack_rise = scl_rise && (bit_cnt_r == `NVS_ACK_SLOT);
    // a clock rise that counts: only inside a transfer
    wire bit_rise = scl_rise && (state_r != ST_IDLE);

    function [AW-1:0] addr_inc;
        input [AW-1:0] a;
        begin
            addr_inc = a + 1'b1;
        end
    endfunction

    // device word carries our type code in its upper nibble
    function type_ok;
        input [DW-1:0] b;
        begin
            type_ok = (b[`NVS_TYPE_MSB:`NVS_TYPE_LSB] == TYPE_CODE);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // write path through fifo into the array
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [FW-1:0] fifo_out_data;
    wire wr_push = byte_done && (state_r == ST_WRDATA) && !wp_s2_r &&
        fifo_in_ready;

    nvs_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH),
        .AW(2)
    ) u_fifo (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .in_valid(wr_push),
        .in_ready(fifo_in_ready),
        .in_data({addr_r, rx_byte}),
        .out_valid(fifo_out_valid),
        .out_ready(1'b1),
        .out_data(fifo_out_data)
    );

    wire [DW-1:0] rd_data;
    nvs_array #(
        .AW(AW),
        .DW(DW),
        .DEPTH(DEPTH)
    ) u_array (
        .sys_clk(sys_clk),
        .wr_en(fifo_out_valid),
        .wr_addr(fifo_out_data[FW-1:DW]),
        .wr_data(fifo_out_data[DW-1:0]),
        .rd_addr(addr_r),
        .rd_data(rd_data)
    );

    ////////////////////////////////////////////////////////////////////////
    always @* begin
        state_nxt = state_r;
        if (start_det)
            state_nxt = ST_DEVADR;
        else if (stop_det)
            state_nxt = ST_IDLE;
        else begin
            case (state_r)
                ST_IDLE: state_nxt = ST_IDLE;
                ST_DEVADR: begin
                    if (byte_done) begin
                        if (!type_ok(rx_byte))
                            state_nxt = ST_IDLE;
                    end else if (ack_rise) begin
                        if (shift_r[`NVS_RNW_BIT])
                            state_nxt = ST_RDDATA;
                        else
                            state_nxt = ST_LOWADR;
                    end
                end
                ST_LOWADR: begin
                    if (ack_rise)
                        state_nxt = ST_WRDATA;
                end
                ST_WRDATA: state_nxt = ST_WRDATA;
                ST_RDDATA: begin
                    if (byte_done)
                        state_nxt = ST_RDACK;
                end
                ST_RDACK: begin
                    if (ack_rise)
                        state_nxt = sda_s2_r ? ST_IDLE : ST_RDDATA;
                end
                default: state_nxt = ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // bit position within the nine-clock byte frame
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_cnt_r <= `NVS_CNT_RST;
        end else if (start_det || stop_det) begin
            bit_cnt_r <= `NVS_CNT_RST;
        end else if (bit_rise) begin
            if (bit_cnt_r == `NVS_ACK_SLOT)
                bit_cnt_r <= `NVS_CNT_RST;
            else
                bit_cnt_r <= bit_cnt_r + 1'b1;
        end
    end

    // receive shift register, msb first, skips the acknowledge clock
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            shift_r <= `NVS_BYTE_RST;
        else if (bit_rise && bit_cnt_r != `NVS_ACK_SLOT)
            shift_r <= rx_byte;
    end

    // acknowledge: armed at the eighth rise, driven over the ninth clock
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_pend_r <= 1'b0;
            ack_slot_r <= 1'b0;
        end else if (start_det || stop_det) begin
            ack_pend_r <= 1'b0;
            ack_slot_r <= 1'b0;
        end else begin
            // acknowledge every received byte except a mismatched device word, protected or not
            if (bit_rise && byte_done)
                ack_pend_r <= (state_r != ST_RDDATA) &&
                    !(state_r == ST_DEVADR && !type_ok(rx_byte));
            else if (scl_fall && bit_cnt_r == `NVS_CNT_RST)
                ack_pend_r <= 1'b0;
            if (scl_fall)
                ack_slot_r <= ack_pend_r && (bit_cnt_r == `NVS_ACK_SLOT);
        end
    end

    // memory address: loaded from the address bytes, then advanced
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_r <= `NVS_ADDR_RST;
        end else if (bit_rise && byte_done) begin
            if (state_r == ST_DEVADR)
                addr_r <= {rx_byte[`NVS_UPPER_MSB:`NVS_UPPER_LSB],
                    addr_r[DW-1:0]};
            else if (state_r == ST_LOWADR)
                addr_r <= {addr_r[AW-1:DW], rx_byte};
        end else if (bit_rise && ack_rise) begin
            // advance after a written byte or an acked read byte
            if (state_r == ST_WRDATA ||
                (state_r == ST_RDACK && !sda_s2_r))
                addr_r <= addr_inc(addr_r);
        end
    end

    // transmit register: loaded at the first fall, shifted on the rest
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_r <= `NVS_BYTE_RST;
        end else if (scl_fall && state_r == ST_RDDATA) begin
            if (bit_cnt_r == `NVS_CNT_RST)
                tx_r <= rd_data;
            else
                tx_r <= {tx_r[DW-2:0], 1'b1};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // open-drain drive: only ever pull low, otherwise release
    reg drive_low;
    always @* begin
        drive_low = 1'b0;
        if (ack_slot_r)
            drive_low = 1'b1;
        else if (state_r == ST_RDDATA && !tx_r[DW-1])
            drive_low = 1'b1;
    end

    // the level driven is always low; only the enable ever moves
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            sda_out <= 1'b0;
        else
            sda_out <= 1'b0;
    end

    // change only after a falling clock; released on start/stop
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            sda_oe <= 1'b0;
        else if (start_det || stop_det)
            sda_oe <= 1'b0;
        else if (scl_fall)
            sda_oe <= 1'b0;
        else if (!scl_s2_r)
            sda_oe <= drive_low;
    end

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            busy_active <= 1'b0;
        else
            busy_active <= (state_r != ST_IDLE);
    end
endmodule
`default_nettype wire

// ---- src/nvs_map.vh ----
`ifndef NVS_MAP_VH
`define NVS_MAP_VH
// device address word layout
`define NVS_TYPE_MSB 7
`define NVS_TYPE_LSB 4
`define NVS_UPPER_MSB 3
`define NVS_UPPER_LSB 1
`define NVS_RNW_BIT 0
// memory geometry
`define NVS_ADDR_W 11
`define NVS_DATA_W 8
`define NVS_DEPTH 2048
// reset values
`define NVS_ADDR_RST 11'h000
`define NVS_BYTE_RST 8'h00
`define NVS_CNT_RST 4'h0
// bits per byte and acknowledge slot position
`define NVS_ACK_SLOT 4'h8
`define NVS_LAST_DATA_BIT 4'h7
// fifo geometry
`define NVS_FIFO_DEPTH 4
`endif

// ---- src/nvs_fifo.v ----
`timescale 1ns/1ps
`default_nettype none
// small synchronous fifo with valid/ready on both sides
module nvs_fifo #(
    parameter WIDTH = 19,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire sys_clk,
    input wire reset_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] count_r;
    wire push;
    wire pop;

    function [AW-1:0] ptr_inc;
        input [AW-1:0] p;
        begin
            if (p == DEPTH - 1)
                ptr_inc = {AW{1'b0}};
            else
                ptr_inc = p + 1'b1;
        end
    endfunction

    assign in_ready = (count_r != DEPTH);
    assign out_valid = (count_r != 0);
    assign out_data = mem_r[rd_ptr_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge sys_clk) begin
        if (push)
            mem_r[wr_ptr_r] <= in_data;
    end

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else begin
            if (push)
                wr_ptr_r <= ptr_inc(wr_ptr_r);
            if (pop)
                rd_ptr_r <= ptr_inc(rd_ptr_r);
            if (push && !pop)
                count_r <= count_r + 1'b1;
            else if (pop && !push)
                count_r <= count_r - 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- src/nvs_array.v ----
`timescale 1ns/1ps
`default_nettype none
// byte-wide storage array, one byte written per access
module nvs_array #(
    parameter AW = 11,
    parameter DW = 8,
    parameter DEPTH = 2048
) (
    input wire sys_clk,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [DW-1:0] wr_data,
    input wire [AW-1:0] rd_addr,
    output reg [DW-1:0] rd_data
);
    reg [DW-1:0] mem_r [0:DEPTH-1];

    always @(posedge sys_clk) begin
        if (wr_en)
            mem_r[wr_addr] <= wr_data;
        rd_data <= mem_r[rd_addr];
    end
endmodule
`default_nettype wire

// ---- bench/nvs_slave_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module nvs_slave_properties (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic wp_in,
    input wire logic busy_active
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    logic scl_d_r;
    logic sda_d_r;
    logic [3:0] since_start_r;
    logic [3:0] since_fall_r;
    // cycles since the last start and the last clock fall, saturating
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            since_start_r <= 4'hF;
            since_fall_r <= 4'hF;
        end else begin
            scl_d_r <= scl_in;
            sda_d_r <= sda_in;
            if (scl_in && scl_d_r && sda_d_r && !sda_in)
                since_start_r <= 4'h0;
            else if (since_start_r != 4'hF)
                since_start_r <= since_start_r + 4'h1;
            if (scl_d_r && !scl_in)
                since_fall_r <= 4'h0;
            else if (since_fall_r != 4'hF)
                since_fall_r <= since_fall_r + 4'h1;
        end
    end
    sequence start_s;
        scl_in && $past(scl_in) && $fell(sda_in);
    endsequence
    sequence stop_s;
        scl_in && $past(scl_in) && $rose(sda_in);
    endsequence
    chk_open_drain: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    chk_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data line changed while clock high");
    chk_oe_after_fall: assert property (
        $changed(sda_oe) |-> since_fall_r <= 4'h7)
        else $error("data line changed late after clock fall");
    chk_idle_release: assert property (!busy_active |-> !sda_oe)
        else $error("data line pulled while in standby");
    chk_start_wakes: assert property (start_s |-> ##[1:8] busy_active)
        else $error("start not taken");
    chk_stop_idles: assert property (stop_s |-> ##[1:8] !busy_active)
        else $error("stop did not return to standby");
    chk_no_self_start: assert property (
        $rose(busy_active) |-> since_start_r <= 4'h8)
        else $error("activity without a start");
    chk_reset_quiet: assert property (
        $rose(reset_n) |-> !sda_oe && !busy_active)
        else $error("outputs active out of reset");
endmodule
bind nvs_slave nvs_slave_properties chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .wp_in(wp_in), .busy_active(busy_active));
`default_nettype wire

// ---- bench/nvs_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// bus master: owns the serial clock, shares the data line
module nvs_master_model (
    output logic scl,
    output logic m_oe,
    input wire logic sda
);
    initial scl = 1'b1;
    initial m_oe = 1'b0;
    task automatic ph(input logic c, input logic o);
        #40;
        scl = c;
        m_oe = o;
    endtask
    // data moves only while the clock is low
    task automatic xfer_bit(input logic b, output logic r);
        ph(1'b0, !b);
        ph(1'b1, !b);
        #20;
        r = sda;
        #25;
        scl = 1'b0;
    endtask
    task automatic start;
        ph(scl, 1'b0);
        ph(1'b1, 1'b0);
        ph(1'b1, 1'b1);
        ph(1'b0, 1'b1);
    endtask
    task automatic stop;
        ph(1'b0, 1'b1);
        ph(1'b1, 1'b1);
        ph(1'b1, 1'b0);
        ph(1'b1, 1'b0);
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xfer_bit(d[i], r);
        xfer_bit(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) xfer_bit(1'b1, d[i]);
        xfer_bit(last, r);
    endtask
endmodule
`default_nettype wire

// ---- bench/nvs_slave_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module nvs_slave_bench;
    localparam logic [3:0] TC = 4'h6; // arbitrary type code
    localparam int LIMIT = 20000;
    logic sys_clk, reset_n, wp_in;
    int n_fail = 0, n_checks = 0, cycles = 0;
    wire logic scl, m_oe, sda_out, sda_oe, busy_active;
    // pull-up: high unless a party pulls the line
    wire logic sda = !m_oe && (sda_oe ? sda_out : 1'b1);
    nvs_slave #(.TYPE_CODE(TC)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .wp_in(wp_in), .busy_active(busy_active));
    nvs_master_model m (.scl(scl), .m_oe(m_oe), .sda(sda));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = !sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_fail++;
            $display("Error at %0t: timeout", $time);
            stop_test;
        end
    end
    task stop_test;
        if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] want);
        n_checks++;
        if (got !== want) begin
            n_fail++;
            $display("Error at %0t: got %h, expected %h", $time, got, want);
        end
    endtask
    task automatic set_wp(input logic v);
        @(posedge sys_clk);
        #1 wp_in = v;
        repeat (4) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [10:0] a, input logic [7:0] d0, d1);
        logic k;
        m.start;
        m.wbyte({TC, a[10:8], 1'b0}, k);
        check({7'h00, k}, 8'h01);
        m.wbyte(a[7:0], k);
        check({7'h00, k}, 8'h01);
        m.wbyte(d0, k);
        check({7'h00, k}, 8'h01);
        m.wbyte(d1, k);
        check({7'h00, k}, 8'h01);
        m.stop;
    endtask
    // random read of two bytes from address a
    task automatic rd(input logic [10:0] a, input logic [7:0] e0, e1);
        logic k;
        logic [7:0] d;
        m.start;
        m.wbyte({TC, a[10:8], 1'b0}, k);
        m.wbyte(a[7:0], k);
        m.start;
        m.wbyte({TC, a[10:8], 1'b1}, k);
        check({7'h00, k}, 8'h01);
        m.rbyte(1'b0, d);
        check(d, e0);
        m.rbyte(1'b1, d);
        check(d, e1);
        m.stop;
    endtask
    task automatic t_wrap;
        set_wp(1'b0);
        wr(11'h7FF, 8'hA5, 8'h3C);
        rd(11'h7FF, 8'hA5, 8'h3C);
    endtask
    task automatic t_protect;
        wr(11'h123, 8'hC3, 8'h96);
        set_wp(1'b1);
        wr(11'h123, 8'h5A, 8'h69);
        rd(11'h123, 8'hC3, 8'h96);
        set_wp(1'b0);
    endtask
    task automatic t_bad_type;
        logic k;
        m.start;
        m.wbyte({~TC, 3'h2, 1'b0}, k);
        check({7'h00, k}, 8'h00);
        check({7'h00, busy_active}, 8'h00);
        m.stop;
        repeat (10) @(posedge sys_clk);
        #1;
        check({7'h00, busy_active}, 8'h00);
    endtask
    // start arrives after three bits of the address byte
    task automatic t_restart;
        logic k;
        logic r;
        m.start;
        m.wbyte({TC, 3'h0, 1'b0}, k);
        repeat (3) m.xfer_bit(1'b1, r);
        check({7'h00, busy_active}, 8'h01);
        wr(11'h055, 8'h77, 8'h88);
        rd(11'h055, 8'h77, 8'h88);
    endtask
    initial begin
        reset_n = 1'b0;
        wp_in = 1'b0;
        repeat (10) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        t_wrap;
        t_protect;
        t_bad_type;
        t_restart;
        stop_test;
    end
endmodule
`default_nettype wire
